/* File: core/scd_pkg.sv */
// Package: register map, fields, reset values and types of the system clock divider control
package scd_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned SCD_DATA_W = 8;
	localparam int unsigned SCD_ADDR_W = 8;
	localparam int unsigned SCD_CPU_W  = 4;
	localparam int unsigned SCD_PRE_W  = 12;
	localparam int unsigned SCD_BT_W   = 8;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] SCD_CLK_SETUP_OFS = 8'hd4;
	localparam logic [7:0] SCD_SRC_SEL_OFS   = 8'hd6;
	localparam logic [7:0] SCD_BT_SETUP_OFS  = 8'hdc;
	localparam logic [7:0] SCD_BT_COUNT_OFS  = 8'hdd;

	// ==========================================================
	// Field positions
	localparam int unsigned SCD_WAKE_DIS_BIT   = 7;
	localparam int unsigned SCD_CPU_DIV_LSB    = 3;
	localparam int unsigned SCD_CPU_DIV_MSB    = 4;
	localparam int unsigned SCD_BT_SEL_LSB     = 2;
	localparam int unsigned SCD_BT_SEL_MSB     = 3;
	localparam int unsigned SCD_BT_CNT_CLR_BIT = 1;
	localparam int unsigned SCD_BT_DIV_CLR_BIT = 0;
	localparam int unsigned SCD_SRC_SEL_BIT    = 0;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		SCD_CPU_DIV16 = 2'h0,
		SCD_CPU_DIV8  = 2'h1,
		SCD_CPU_DIV2  = 2'h2,
		SCD_CPU_DIV1  = 2'h3
	} scd_cpu_div_t;

	typedef enum logic [1:0] {
		SCD_BT_SRC_4096 = 2'h0,
		SCD_BT_SRC_1024 = 2'h1,
		SCD_BT_SRC_128  = 2'h2,
		SCD_BT_SRC_OFF  = 2'h3
	} scd_bt_src_t;

	// ==========================================================
	// Reset values
	localparam scd_cpu_div_t SCD_CPU_DIV_RST  = SCD_CPU_DIV16;
	localparam scd_bt_src_t  SCD_BT_SEL_RST   = SCD_BT_SRC_4096;
	localparam logic         SCD_WAKE_DIS_RST = 1'h0;
	localparam logic         SCD_SRC_SEL_RST  = 1'h0;
	localparam logic [7:0]   SCD_ZERO_BYTE    = 8'h00;

	// ==========================================================
	// Divider tap masks: a tap fires when all masked bits are ones
	localparam logic [3:0]  SCD_CPU_MASK_16 = 4'hf;
	localparam logic [3:0]  SCD_CPU_MASK_8  = 4'h7;
	localparam logic [3:0]  SCD_CPU_MASK_2  = 4'h1;
	localparam logic [3:0]  SCD_CPU_MASK_1  = 4'h0;
	localparam logic [11:0] SCD_PRE_MASK_4096 = 12'hfff;
	localparam logic [11:0] SCD_PRE_MASK_1024 = 12'h3ff;
	localparam logic [11:0] SCD_PRE_MASK_128  = 12'h07f;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} scd_bus_req_t;

	typedef struct packed {
		logic main_tick;
		logic sub_tick;
	} scd_osc_t;

endpackage : scd_pkg

/* File: core/scd_div.sv */
// Free-running counter with synchronous clear, used for every divider stage
`timescale 1ns/100ps
`default_nettype none

module scd_div
	import scd_pkg::*;
#(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Control
	input  wire logic             clr,
	input  wire logic             en,
	// Count
	output logic [WIDTH-1:0]      cnt,
	output logic                  wrap
);

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// ==========================================================
	// Next count: clear wins over counting
	always_comb begin
		cnt_d = cnt_q;
		if (clr) begin
			cnt_d = '0;
		end else if (en) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign cnt  = cnt_q;
	assign wrap = en & (&cnt_q) & ~clr;

endmodule : scd_div

`default_nettype wire

/* File: core/scd_top.sv */
// System clock divider control: CPU clock divider, basic timer clears, wake-up gate
// ==========================================================
// Overview of operation
// - Writing counter-clear zeroes timer, bit self-clears
// - Writing divider-clear zeroes prescaler, bit self-clears
// - All dividers run from selected oscillator
// - Bits 4:3 pick divide 16, 8, 2, 1
// - Reset selects divide by sixteen
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module scd_top
	import scd_pkg::*;
(
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// Register port
	input  wire scd_bus_req_t  bus_req,
	output logic [7:0]         rd_data,
	// Oscillator ticks, one cycle each
	input  wire scd_osc_t      osc,
	// Wake-up request from the main oscillator
	input  wire logic          osc_wake_req,
	// Clock enables and timer
	output logic               fxx_tick,
	output logic               cpu_clk_en,
	output logic               bt_tick,
	output logic               bt_overflow,
	output logic [7:0]         bt_count,
	// Status
	output logic               fxx_src_sub,
	output logic               osc_wake_irq_en,
	output logic               osc_wake_irq
);

	// ==========================================================
	// Register state
	scd_cpu_div_t cpu_div_q;
	scd_cpu_div_t cpu_div_d;
	scd_bt_src_t  bt_sel_q;
	scd_bt_src_t  bt_sel_d;
	logic         wake_dis_q;
	logic         wake_dis_d;
	logic         src_sub_q;
	logic         src_sub_d;
	logic [7:0]   rd_data_q;
	logic [7:0]   rd_data_d;

	logic         wr_clk;
	logic         wr_src;
	logic         wr_bt;
	logic         bt_cnt_clr;
	logic         pre_clr;

	// ==========================================================
	// Address decode
	assign wr_clk = bus_req.wr && (bus_req.addr == SCD_CLK_SETUP_OFS);
	assign wr_src = bus_req.wr && (bus_req.addr == SCD_SRC_SEL_OFS);
	assign wr_bt  = bus_req.wr && (bus_req.addr == SCD_BT_SETUP_OFS);

	// Clear commands are pulses; nothing stores them, so they read back as zero
	assign bt_cnt_clr = wr_bt && bus_req.wdata[SCD_BT_CNT_CLR_BIT];
	assign pre_clr    = wr_bt && bus_req.wdata[SCD_BT_DIV_CLR_BIT];

	// ==========================================================
	// Register writes
	always_comb begin
		cpu_div_d  = cpu_div_q;
		bt_sel_d   = bt_sel_q;
		wake_dis_d = wake_dis_q;
		src_sub_d  = src_sub_q;
		if (wr_clk) begin
			cpu_div_d  = scd_cpu_div_t'(bus_req.wdata[SCD_CPU_DIV_MSB:SCD_CPU_DIV_LSB]);
			wake_dis_d = bus_req.wdata[SCD_WAKE_DIS_BIT];
		end
		if (wr_src) begin
			src_sub_d = bus_req.wdata[SCD_SRC_SEL_BIT];
		end
		if (wr_bt) begin
			bt_sel_d = scd_bt_src_t'(bus_req.wdata[SCD_BT_SEL_MSB:SCD_BT_SEL_LSB]);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cpu_div_q  <= SCD_CPU_DIV_RST;
			bt_sel_q   <= SCD_BT_SEL_RST;
			wake_dis_q <= SCD_WAKE_DIS_RST;
			src_sub_q  <= SCD_SRC_SEL_RST;
		end else begin
			cpu_div_q  <= cpu_div_d;
			bt_sel_q   <= bt_sel_d;
			wake_dis_q <= wake_dis_d;
			src_sub_q  <= src_sub_d;
		end
	end

	// ==========================================================
	// Reference clock: the selected oscillator only
	assign fxx_tick    = src_sub_q ? osc.sub_tick : osc.main_tick;
	assign fxx_src_sub = src_sub_q;

	// ==========================================================
	// CPU clock divider
	logic [3:0] cpu_cnt;
	logic [3:0] cpu_mask;

	scd_div #(
		.WIDTH (SCD_CPU_W)
	) u_cpu_div (
		.mclk (mclk),
		.rst  (rst),
		.clr  (1'b0),
		.en   (fxx_tick),
		.cnt  (cpu_cnt),
		.wrap ()
	);

	always_comb begin
		unique case (cpu_div_q)
			SCD_CPU_DIV16: cpu_mask = SCD_CPU_MASK_16;
			SCD_CPU_DIV8:  cpu_mask = SCD_CPU_MASK_8;
			SCD_CPU_DIV2:  cpu_mask = SCD_CPU_MASK_2;
			SCD_CPU_DIV1:  cpu_mask = SCD_CPU_MASK_1;
		endcase
	end

	// A divide change takes effect at once; the first slow pulse may come early
	assign cpu_clk_en = fxx_tick && ((cpu_cnt & cpu_mask) == cpu_mask);

	// ==========================================================
	// Basic timer prescaler and counter
	logic [11:0] pre_cnt;
	logic [11:0] pre_mask;

	scd_div #(
		.WIDTH (SCD_PRE_W)
	) u_pre_div (
		.mclk (mclk),
		.rst  (rst),
		.clr  (pre_clr),
		.en   (fxx_tick),
		.cnt  (pre_cnt),
		.wrap ()
	);

	always_comb begin
		unique case (bt_sel_q)
			SCD_BT_SRC_4096: pre_mask = SCD_PRE_MASK_4096;
			SCD_BT_SRC_1024: pre_mask = SCD_PRE_MASK_1024;
			SCD_BT_SRC_128:  pre_mask = SCD_PRE_MASK_128;
			SCD_BT_SRC_OFF:  pre_mask = SCD_PRE_MASK_4096;
		endcase
	end

	// Tap is held off while the prescaler is being cleared
	assign bt_tick = fxx_tick && !pre_clr && (bt_sel_q != SCD_BT_SRC_OFF)
		&& ((pre_cnt & pre_mask) == pre_mask);

	scd_div #(
		.WIDTH (SCD_BT_W)
	) u_bt_cnt (
		.mclk (mclk),
		.rst  (rst),
		.clr  (bt_cnt_clr),
		.en   (bt_tick),
		.cnt  (bt_count),
		.wrap (bt_overflow)
	);

	// ==========================================================
	// Wake-up interrupt gate
	assign osc_wake_irq_en = !wake_dis_q;
	assign osc_wake_irq    = osc_wake_req && !wake_dis_q;

	// ==========================================================
	// Read data, valid in the cycle after the read strobe
	always_comb begin
		rd_data_d = SCD_ZERO_BYTE;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				SCD_CLK_SETUP_OFS: begin
					rd_data_d[SCD_WAKE_DIS_BIT] = wake_dis_q;
					rd_data_d[SCD_CPU_DIV_MSB:SCD_CPU_DIV_LSB] = cpu_div_q;
				end
				SCD_SRC_SEL_OFS: begin
					rd_data_d[SCD_SRC_SEL_BIT] = src_sub_q;
				end
				SCD_BT_SETUP_OFS: begin
					rd_data_d[SCD_BT_SEL_MSB:SCD_BT_SEL_LSB] = bt_sel_q;
				end
				SCD_BT_COUNT_OFS: begin
					rd_data_d = bt_count;
				end
				default: begin
					rd_data_d = SCD_ZERO_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_data_q <= SCD_ZERO_BYTE;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data = rd_data_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_cnt_clear_wr;
		bus_req.wr && (bus_req.addr == SCD_BT_SETUP_OFS) && bus_req.wdata[SCD_BT_CNT_CLR_BIT];
	endsequence

	sequence s_div_clear_wr;
		bus_req.wr && (bus_req.addr == SCD_BT_SETUP_OFS) && bus_req.wdata[SCD_BT_DIV_CLR_BIT];
	endsequence

	sequence s_bt_setup_rd;
		bus_req.rd && (bus_req.addr == SCD_BT_SETUP_OFS);
	endsequence

	a_timer_count_clear: assert property (
		s_cnt_clear_wr |=> (bt_count == SCD_ZERO_BYTE))
		else $error("basic timer count not zero after clear");

	a_clear_bits_zero: assert property (
		(s_div_clear_wr or s_cnt_clear_wr) ##[1:2] s_bt_setup_rd |=> (rd_data[1:0] == 2'h0))
		else $error("clear bits did not read back as zero");

	a_prescaler_clear: assert property (
		s_div_clear_wr |=> (pre_cnt == 12'h000))
		else $error("prescaler not zero after divider clear");

	a_source_follow: assert property (
		fxx_src_sub && osc.main_tick && !osc.sub_tick |-> !fxx_tick)
		else $error("main oscillator tick used while sub oscillator selected");

	a_div16_period: assert property (
		(cpu_div_q == SCD_CPU_DIV16) && cpu_clk_en |-> (cpu_cnt == SCD_CPU_MASK_16))
		else $error("divide by sixteen pulse at wrong count");

	a_div1_pass: assert property (
		(cpu_div_q == SCD_CPU_DIV1) && fxx_tick |-> cpu_clk_en)
		else $error("undivided setting dropped a tick");

	a_reset_slowest: assert property (
		$past(rst) |-> (cpu_div_q == SCD_CPU_DIV16) && osc_wake_irq_en)
		else $error("reset did not select divide by sixteen");

	a_wake_gate: assert property (
		osc_wake_req && wake_dis_q |-> !osc_wake_irq)
		else $error("wake interrupt passed while disabled");

endmodule : scd_top

`default_nettype wire

/* File: tb/scd_top_tb_top.sv */
// Testbench for the system clock divider control
`timescale 1ns/100ps
`default_nettype none

module scd_top_tb_top;
	import scd_pkg::*;

	// ==========================================================
	// Signals
	logic         mclk;
	logic         rst;
	scd_bus_req_t bus_req;
	logic [7:0]   rd_data;
	scd_osc_t     osc;
	logic         osc_wake_req;
	logic         fxx_tick;
	logic         cpu_clk_en;
	logic         bt_tick;
	logic         bt_overflow;
	logic [7:0]   bt_count;
	logic         fxx_src_sub;
	logic         osc_wake_irq_en;
	logic         osc_wake_irq;
	int           miscompares;
	int           n_tests;
	int           pulses;
	int           fx;
	logic [7:0]   d;
	int           divs [4] = '{16, 8, 2, 1};

	scd_top uut (
		.mclk            (mclk),
		.rst             (rst),
		.bus_req         (bus_req),
		.rd_data         (rd_data),
		.osc             (osc),
		.osc_wake_req    (osc_wake_req),
		.fxx_tick        (fxx_tick),
		.cpu_clk_en      (cpu_clk_en),
		.bt_tick         (bt_tick),
		.bt_overflow     (bt_overflow),
		.bt_count        (bt_count),
		.fxx_src_sub     (fxx_src_sub),
		.osc_wake_irq_en (osc_wake_irq_en),
		.osc_wake_irq    (osc_wake_irq)
	);

	// ==========================================================
	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ==========================================================
	// Tasks
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask : wr

	// Read data is only valid in the single cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1 v = rd_data;
	endtask : rd

	// Ticks every cycle, counting CPU enables and source ticks seen
	task automatic tick(input int n, input logic m, input logic s, output int p, output int f);
		p = 0;
		f = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			osc <= '{main_tick: m, sub_tick: s};
			#1 p += int'(cpu_clk_en === 1'b1);
			f += int'(fxx_tick === 1'b1);
		end
		@(posedge mclk);
		osc <= '{main_tick: 1'b0, sub_tick: 1'b0};
		// Let the last counted tick settle before any caller samples outputs
		#1;
	endtask : tick

	// ==========================================================
	// Watchdog, far beyond the under one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		end_sim();
	end

	// ==========================================================
	// Tests
	initial begin
		miscompares = 0;
		n_tests = 0;
		rst = 1'b1;
		bus_req = '0;
		osc = '0;
		osc_wake_req = 1'b0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(SCD_CLK_SETUP_OFS, d);
		chk("clk setup reset", 8'h00, d);
		chk("wake en reset", 8'h01, {7'h00, osc_wake_irq_en});
		tick(32, 1'b1, 1'b0, pulses, fx);
		chk("reset div pulses", 8'h02, 8'(pulses));
		for (int i = 0; i < 4; i++) begin
			wr(SCD_CLK_SETUP_OFS, 8'(i << 3));
			rd(SCD_CLK_SETUP_OFS, d);
			chk("clk setup", 8'(i << 3), d);
			tick(32, 1'b1, 1'b0, pulses, fx);
			chk("div pulses", 8'(32 / divs[i]), 8'(pulses));
		end
		// Wake gate
		osc_wake_req <= 1'b1;
		wr(SCD_CLK_SETUP_OFS, 8'h80);
		#1 chk("wake irq off", 8'h00, {7'h00, osc_wake_irq});
		chk("wake en off", 8'h00, {7'h00, osc_wake_irq_en});
		rd(SCD_CLK_SETUP_OFS, d);
		chk("clk setup wake", 8'h80, d);
		wr(SCD_CLK_SETUP_OFS, 8'h00);
		#1 chk("wake irq on", 8'h01, {7'h00, osc_wake_irq});
		osc_wake_req <= 1'b0;
		// Source select
		wr(SCD_SRC_SEL_OFS, 8'h01);
		#1 chk("source sub", 8'h01, {7'h00, fxx_src_sub});
		tick(16, 1'b1, 1'b0, pulses, fx);
		chk("main ignored", 8'h00, 8'(fx));
		tick(16, 1'b0, 1'b1, pulses, fx);
		chk("sub ticks", 8'h10, 8'(fx));
		chk("sub pulses", 8'h01, 8'(pulses));
		wr(SCD_SRC_SEL_OFS, 8'h00);
		// Basic timer at /128, both clears at once
		wr(SCD_BT_SETUP_OFS, 8'h0b);
		rd(SCD_BT_COUNT_OFS, d);
		chk("count cleared", 8'h00, d);
		rd(SCD_BT_SETUP_OFS, d);
		chk("clear bits self clear", 8'h08, d);
		tick(384, 1'b1, 1'b0, pulses, fx);
		chk("count after 384", 8'h03, bt_count);
		tick(100, 1'b1, 1'b0, pulses, fx);
		wr(SCD_BT_SETUP_OFS, 8'h09);
		rd(SCD_BT_COUNT_OFS, d);
		chk("count kept", 8'h03, d);
		tick(127, 1'b1, 1'b0, pulses, fx);
		chk("prescaler restarted", 8'h03, bt_count);
		tick(1, 1'b1, 1'b0, pulses, fx);
		chk("count after 128", 8'h04, bt_count);
		wr(SCD_BT_SETUP_OFS, 8'h0a);
		rd(SCD_BT_COUNT_OFS, d);
		chk("count clear", 8'h00, d);
		// Unmapped place
		wr(8'h10, 8'hff);
		rd(8'h10, d);
		chk("unmapped", 8'h00, d);
		end_sim();
	end

endmodule : scd_top_tb_top

`default_nettype wire
